// >>> sbsc_regs.svh
// Constants shared by both ends of the burst SRAM link.
// Assumes inclusion by bare name from any file of the block.
`ifndef SBSC_REGS_SVH
`define SBSC_REGS_SVH
// ****************************************
// Widths and strap defaults
// ****************************************
`define SBSC_ADDR_W 18
`define SBSC_LANES 2
`define SBSC_LANE_W 9
`define SBSC_ORDER_RST 1'b1
// ****************************************
// Timing
// ****************************************
`define SBSC_CLK_NS 10
`define SBSC_SLEEP_ENTER_CYC 2
`define SBSC_SLEEP_REC_CYC 2
`endif

// >>> sbsc_pkg.sv
// Types shared by both ends of the burst SRAM link.
// Assumes the constants header is in the same folder.
`include "sbsc_regs.svh"
package sbsc_pkg;
  typedef logic [`SBSC_ADDR_W-1:0] sbsc_addr_t;
  typedef logic [`SBSC_LANES*`SBSC_LANE_W-1:0] sbsc_data_t;
  typedef enum logic [3:0]
  {
    SBSC_AWAKE = 4'h1,
    SBSC_ENTER = 4'h2,
    SBSC_ASLEEP = 4'h4,
    SBSC_WAKE = 4'h8
  } sbsc_sleep_e;
  typedef enum logic [3:0]
  {
    SBSC_C_IDLE = 4'h1,
    SBSC_C_RUN = 4'h2,
    SBSC_C_SLEEP = 4'h4,
    SBSC_C_REC = 4'h8
  } sbsc_ctl_e;
endpackage : sbsc_pkg

// >>> sbsc_link_if.sv
// Pin-level link between the SRAM device end and its controller end.
// Assumes the testbench resolves the shared data wire from the enables.
`timescale 1ns/10ps
interface sbsc_link_if;
  import sbsc_pkg::*;
  sbsc_addr_t addr;
  logic chip_select_primary_n;
  logic chip_select_expand_hi;
  logic chip_select_expand_n;
  logic processor_addr_strobe_n;
  logic controller_addr_strobe_n;
  logic burst_advance_n;
  logic global_write_n;
  logic byte_write_enable_n;
  logic [`SBSC_LANES-1:0] byte_lane_select_n;
  logic outEnableN;
  logic sleep_request;
  logic burstOrder;
  sbsc_data_t dqFromCtl;
  logic dqCtlOeN;
  sbsc_data_t dqFromDev;
  logic dqDevOeN;
  sbsc_data_t dqBus;
  modport device (
    input addr, chip_select_primary_n, chip_select_expand_hi, chip_select_expand_n,
    input processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
    input global_write_n, byte_write_enable_n, byte_lane_select_n,
    input outEnableN, sleep_request, burstOrder, dqBus,
    output dqFromDev, dqDevOeN
  );
  modport controller (
    output addr, chip_select_primary_n, chip_select_expand_hi, chip_select_expand_n,
    output processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
    output global_write_n, byte_write_enable_n, byte_lane_select_n,
    output outEnableN, sleep_request, burstOrder, dqFromCtl, dqCtlOeN,
    input dqBus
  );
endinterface : sbsc_link_if

// >>> sbsc_device.sv
// Device end: flow-through burst SRAM with strobes, burst counter and sleep.
// Assumes one clock mclk shared with the controller; link inputs are
// synchronous to mclk, output enable and sleep are sampled as given.
//
// Contract
// RQ1 - Register all synchronous inputs on rising edge
// RQ2 - Two-bit wrapping burst counter from start
// RQ3 - Advance steps counter only when sampled
// RQ4 - Order low linear, high interleaved, default interleaved
// RQ5 - Byte writes qualified; global write writes all
// RQ6 - Three chip selects; clockless output enable
// RQ7 - Read starts on selects plus either strobe
// RQ8 - Processor strobe gated by primary select, reads
// RQ9 - Write controls after processor start write data
// RQ10 - Each lane select governs its byte, parity
// RQ11 - Data drivers off whenever write detected
// RQ12 - Controller releases bus before driving data
// RQ13 - Controller strobe write loads and writes
// RQ14 - Both strobes low: processor strobe wins
// RQ15 - Clockless sleep, two cycles enter, exit
// RQ16 - Contents kept; pending accesses dropped
// RQ17 - Controller deselects around sleep and recovery
// RQ18 - Interleaved: start xor beat index
// RQ19 - Linear: start plus beat, modulo four
// RQ20 - Mask output enable first read after deselect
// RQ21 - Write when byte enable and lane, or global
// RQ22 - No strobe, no advance: repeat current address
`timescale 1ns/10ps
`include "sbsc_regs.svh"
module sbsc_device
  import sbsc_pkg::*;
#(
  parameter int DEPTH_LOG2 = `SBSC_ADDR_W
)
(
  input wire logic mclk,
  input wire logic rst_n,
  sbsc_link_if.device link
);
  localparam int LW = `SBSC_LANE_W;
  localparam int NL = `SBSC_LANES;

  // ****************************************
  // Input registers
  // ****************************************
  sbsc_addr_t addrIn_r;
  logic cs1N_r, cs2_r, cs3N_r, pStrobeN_r, cStrobeN_r, advanceN_r, globalWrN_r, byteWrEnN_r;
  logic [NL-1:0] laneSelN_r;
  sbsc_data_t dIn_r;
  logic order_r;
  // Every link input but output enable and sleep is sampled on the rising edge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addrIn_r <= '0;
      cs1N_r <= 1'b1;
      cs2_r <= 1'b0;
      cs3N_r <= 1'b1;
      pStrobeN_r <= 1'b1;
      cStrobeN_r <= 1'b1;
      advanceN_r <= 1'b1;
      globalWrN_r <= 1'b1;
      byteWrEnN_r <= 1'b1;
      laneSelN_r <= '1;
      dIn_r <= '0;
      order_r <= `SBSC_ORDER_RST; // RQ4
    end
    else
    begin
      addrIn_r <= link.addr; // RQ1
      cs1N_r <= link.chip_select_primary_n;
      cs2_r <= link.chip_select_expand_hi;
      cs3N_r <= link.chip_select_expand_n;
      pStrobeN_r <= link.processor_addr_strobe_n;
      cStrobeN_r <= link.controller_addr_strobe_n;
      advanceN_r <= link.burst_advance_n;
      globalWrN_r <= link.global_write_n;
      byteWrEnN_r <= link.byte_write_enable_n;
      laneSelN_r <= link.byte_lane_select_n;
      dIn_r <= link.dqBus;
      order_r <= link.burstOrder;
    end
  end

  // ****************************************
  // Sleep sequencing
  // ****************************************
  sbsc_sleep_e sleep_r;
  logic [1:0] sleepCnt_r;
  logic awake;
  // Two cycles each way; accesses only run while fully awake
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleep_r <= SBSC_AWAKE;
      sleepCnt_r <= '0;
    end
    else
    begin
      unique case (sleep_r)
        SBSC_AWAKE:
        begin
          sleepCnt_r <= '0;
          if (link.sleep_request) sleep_r <= SBSC_ENTER; // RQ15
        end
        SBSC_ENTER:
        begin
          sleepCnt_r <= sleepCnt_r + 2'h1;
          if (!link.sleep_request) sleep_r <= SBSC_AWAKE;
          else if (sleepCnt_r == 2'(`SBSC_SLEEP_ENTER_CYC - 1)) sleep_r <= SBSC_ASLEEP;
        end
        SBSC_ASLEEP:
        begin
          sleepCnt_r <= '0;
          if (!link.sleep_request) sleep_r <= SBSC_WAKE;
        end
        SBSC_WAKE:
        begin
          sleepCnt_r <= sleepCnt_r + 2'h1;
          if (link.sleep_request) sleep_r <= SBSC_ASLEEP;
          else if (sleepCnt_r == 2'(`SBSC_SLEEP_REC_CYC - 1)) sleep_r <= SBSC_AWAKE; // RQ15
        end
      endcase
    end
  end
  // Sleep pin acts at once, without the clock
  assign awake = (sleep_r == SBSC_AWAKE) && !link.sleep_request; // RQ15 RQ16

  // ****************************************
  // Access decode
  // ****************************************
  logic selAll, pStart, cStart, anyWrite, cWrite, start;
  logic [NL-1:0] laneWr;
  assign selAll = !cs1N_r && cs2_r && !cs3N_r; // RQ6
  assign pStart = awake && !pStrobeN_r && !cs1N_r; // RQ8
  assign anyWrite = !globalWrN_r || (!byteWrEnN_r && (laneSelN_r != '1)); // RQ21
  assign cStart = awake && pStrobeN_r && !cStrobeN_r; // RQ14
  assign start = (pStart || cStart) && selAll; // RQ7
  assign cWrite = cStart && selAll && anyWrite; // RQ13
  // Global write overrides every lane select
  assign laneWr = !globalWrN_r ? '1 : (byteWrEnN_r ? '0 : ~laneSelN_r); // RQ5 RQ10

  // ****************************************
  // Burst counter and access state
  // ****************************************
  logic active_r, deselPrev_r, maskOe_r;
  logic [DEPTH_LOG2-1:2] baseAddr_r;
  logic [1:0] first_r, beat_r, beatNow, low;
  // A sampled advance moves this very access on, so the step and the
  // address it selects never drift a cycle apart
  assign beatNow = advanceN_r ? beat_r : beat_r + 2'h1; // RQ3 RQ22
  // Load on start, step on advance, hold otherwise
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active_r <= 1'b0;
      baseAddr_r <= '0;
      first_r <= '0;
      beat_r <= '0;
    end
    else if (!awake)
      active_r <= 1'b0; // RQ16
    else if (start)
    begin
      active_r <= 1'b1;
      baseAddr_r <= addrIn_r[DEPTH_LOG2-1:2];
      first_r <= addrIn_r[1:0]; // RQ2
      beat_r <= '0;
    end
    else if ((pStart || cStart) && !selAll)
      active_r <= 1'b0;
    else
      beat_r <= beatNow; // RQ3 RQ22
  end
  // Deselect tracking for the first-read output mask
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      deselPrev_r <= 1'b1;
      maskOe_r <= 1'b0;
    end
    else
    begin
      deselPrev_r <= !active_r;
      maskOe_r <= start && deselPrev_r; // RQ20
    end
  end
  // Burst order picks how the beat index meets the start
  assign low = order_r ? (first_r ^ beatNow) : (first_r + beatNow); // RQ18 RQ19

  // ****************************************
  // Memory core
  // ****************************************
  logic [LW-1:0] mem [NL][2**DEPTH_LOG2];
  logic [DEPTH_LOG2-1:0] coreAddr, ldAddr;
  logic writeNow, readNow;
  // A new start uses the freshly sampled address directly (flow-through)
  assign ldAddr = addrIn_r[DEPTH_LOG2-1:0];
  assign coreAddr = start ? ldAddr : {baseAddr_r, low};
  // Processor-start first cycle is always a read
  assign writeNow = awake && anyWrite && !pStart
                    && (cWrite || (active_r && !start)); // RQ9 RQ13
  assign readNow = awake && !writeNow && (start || active_r);
  genvar g;
  generate
    for (g = 0; g < NL; g++)
    begin : gLane
      always_ff @(posedge mclk)
      begin
        if (writeNow && laneWr[g])
          mem[g][coreAddr] <= dIn_r[g*LW +: LW]; // RQ10
      end
    end
  endgenerate

  // ****************************************
  // Read data and output drive
  // ****************************************
  sbsc_data_t dOut_r;
  logic driveOk_r;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dOut_r <= '0;
      driveOk_r <= 1'b0;
    end
    else
    begin
      driveOk_r <= readNow;
      if (readNow)
        dOut_r <= {mem[1][coreAddr], mem[0][coreAddr]};
    end
  end
  assign link.dqFromDev = dOut_r;
  // Write detection or mask forces the drivers off whatever OE says
  assign link.dqDevOeN = !(driveOk_r && !link.outEnableN && !maskOe_r
                           && !anyWrite && awake); // RQ6 RQ11 RQ20
endmodule : sbsc_device

// >>> sbsc_controller.sv
// Controller end: turns single read and write orders into link cycles.
// Assumes a user port on mclk; read data come with the rdValid pulse.
`timescale 1ns/10ps
`include "sbsc_regs.svh"
module sbsc_controller
  import sbsc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire sbsc_addr_t reqAddr,
  input wire sbsc_data_t reqData,
  input wire logic [`SBSC_LANES-1:0] reqLanes,
  input wire logic sleepReq,
  input wire logic orderInterleaved,
  output logic reqReady,
  output logic rdValid,
  output sbsc_data_t rdData,
  output logic sleeping,
  sbsc_link_if.controller link
);
  sbsc_ctl_e st_r;
  logic [2:0] ph_r;
  logic [1:0] cnt_r;
  logic wr_r;
  // Ready only when idle, so a sleep order never races an access
  assign reqReady = (st_r == SBSC_C_IDLE) && !sleepReq;
  // Sequencer: deselect around sleep, release bus before writing
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= SBSC_C_IDLE;
      ph_r <= '0;
      cnt_r <= '0;
      wr_r <= 1'b0;
      link.addr <= '0;
      link.chip_select_primary_n <= 1'b1;
      link.chip_select_expand_hi <= 1'b0;
      link.chip_select_expand_n <= 1'b1;
      link.processor_addr_strobe_n <= 1'b1;
      link.controller_addr_strobe_n <= 1'b1;
      link.burst_advance_n <= 1'b1;
      link.global_write_n <= 1'b1;
      link.byte_write_enable_n <= 1'b1;
      link.byte_lane_select_n <= '1;
      link.outEnableN <= 1'b1;
      link.sleep_request <= 1'b0;
      link.dqFromCtl <= '0;
      link.dqCtlOeN <= 1'b1;
      rdValid <= 1'b0;
      rdData <= '0;
    end
    else
    begin
      rdValid <= 1'b0;
      link.controller_addr_strobe_n <= 1'b1;
      unique case (st_r)
        SBSC_C_IDLE:
        begin
          link.chip_select_primary_n <= 1'b1; // RQ17
          link.byte_write_enable_n <= 1'b1;
          link.byte_lane_select_n <= '1;
          link.dqCtlOeN <= 1'b1;
          link.outEnableN <= 1'b1; // RQ12
          if (sleepReq)
          begin
            link.sleep_request <= 1'b1; // RQ17
            st_r <= SBSC_C_SLEEP;
          end
          else if (reqValid)
          begin
            wr_r <= reqWrite;
            link.addr <= reqAddr;
            link.chip_select_primary_n <= 1'b0;
            link.chip_select_expand_hi <= 1'b1;
            link.chip_select_expand_n <= 1'b0;
            link.controller_addr_strobe_n <= 1'b0; // RQ13
            link.byte_write_enable_n <= !reqWrite;
            link.byte_lane_select_n <= reqWrite ? ~reqLanes : '1;
            link.dqFromCtl <= reqData;
            link.dqCtlOeN <= !reqWrite; // RQ12
            link.outEnableN <= reqWrite;
            ph_r <= '0;
            st_r <= SBSC_C_RUN;
          end
        end
        SBSC_C_RUN:
        begin
          link.chip_select_primary_n <= 1'b1;
          link.byte_write_enable_n <= 1'b1;
          link.byte_lane_select_n <= '1;
          link.dqCtlOeN <= 1'b1;
          ph_r <= ph_r + 3'h1;
          // Same clock as the device; the cycle before this edge is
          // driven even when the first beat is masked
          if (ph_r == 3'h3)
          begin
            rdValid <= !wr_r;
            rdData <= link.dqBus; // RQ7
            link.outEnableN <= 1'b1;
            st_r <= SBSC_C_IDLE;
          end
        end
        SBSC_C_SLEEP:
        begin
          cnt_r <= '0;
          if (!sleepReq)
          begin
            link.sleep_request <= 1'b0;
            st_r <= SBSC_C_REC;
          end
        end
        SBSC_C_REC:
        begin
          cnt_r <= cnt_r + 2'h1;
          if (cnt_r == 2'(`SBSC_SLEEP_REC_CYC)) st_r <= SBSC_C_IDLE; // RQ17
        end
      endcase
    end
  end
  assign sleeping = (st_r == SBSC_C_SLEEP) || (st_r == SBSC_C_REC);
  assign link.burstOrder = orderInterleaved;
endmodule : sbsc_controller

// >>> sbsc_link_monitor.sv
// Pin checks on the link joining the controller end to the device end.
// Assumes one clock and the levels of the shared link interface.
`timescale 1ns/10ps
module sbsc_link_monitor
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic chip_select_primary_n,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic global_write_n,
  input wire logic byte_write_enable_n,
  input wire logic [1:0] byte_lane_select_n,
  input wire logic outEnableN,
  input wire logic sleep_request,
  input wire logic dqCtlOeN,
  input wire logic dqDevOeN
);
  // Cycle classes at the pins
  wire wr = !global_write_n || (!byte_write_enable_n && !(&byte_lane_select_n));
  wire quiet = chip_select_primary_n && processor_addr_strobe_n && controller_addr_strobe_n;
  wire go = !chip_select_primary_n && !controller_addr_strobe_n && processor_addr_strobe_n;
  // One clock domain, so one default clock and reset
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_oeOff; outEnableN |-> dqDevOeN; endproperty
  a_oeOff: assert property (p_oeOff)
    else $error("device drove with enable high");
  property p_noFight; dqCtlOeN || dqDevOeN; endproperty
  a_noFight: assert property (p_noFight)
    else $error("both ends drove the data wire");
  property p_wrOff; go && wr |=> dqDevOeN [*2]; endproperty
  a_wrOff: assert property (p_wrOff)
    else $error("device drove during a write");
  property p_wrData; go && wr |-> !dqCtlOeN; endproperty
  a_wrData: assert property (p_wrData)
    else $error("write started without data");
  property p_release; !dqCtlOeN |-> outEnableN; endproperty
  a_release: assert property (p_release)
    else $error("controller drove with enable low");
  // Read data may lag one cycle when the first beat is masked
  property p_rdDrive; go && !wr && !outEnableN |-> ##[1:3] !dqDevOeN; endproperty
  a_rdDrive: assert property (p_rdDrive)
    else $error("read never drove the data wire");
  property p_sleepOff; sleep_request [*4] |-> dqDevOeN; endproperty
  a_sleepOff: assert property (p_sleepOff)
    else $error("device drove while asleep");
  property p_sleepQuiet; sleep_request |-> quiet; endproperty
  a_sleepQuiet: assert property (p_sleepQuiet)
    else $error("selected while asleep");
  property p_recover; $fell(sleep_request) |-> quiet [*2]; endproperty
  a_recover: assert property (p_recover)
    else $error("selected during recovery");
  c_read: cover property (go && !wr);
  c_write: cover property (go && wr);
  c_sleep: cover property ($rose(sleep_request));
endmodule : sbsc_link_monitor

// >>> sync_burst_sram_control_tb.sv
// Bench: controller and device on one link, and a second device on a
// link driven here for bursts. Assumes design and monitor files.
`timescale 1ns/10ps
module sync_burst_sram_control_tb
  import sbsc_pkg::*;
;
  logic mclk, rst_n, reqValid, reqWrite, sleepReq, reqReady, rdValid, sleeping;
  logic [1:0] reqLanes;
  sbsc_addr_t reqAddr;
  sbsc_data_t reqData, rdData;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  sbsc_link_if l ();
  sbsc_link_if l2 ();
  // Released wire shows a moving pattern, so stale data never passes
  assign l.dqBus = !l.dqDevOeN ? l.dqFromDev :
    !l.dqCtlOeN ? l.dqFromCtl : sbsc_data_t'(cyc);
  assign l2.dqBus = !l2.dqDevOeN ? l2.dqFromDev :
    !l2.dqCtlOeN ? l2.dqFromCtl : sbsc_data_t'(cyc);
  // 100 MHz clock and cycle count
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;
  // Both ends, the hand-driven device and the link checks
  sbsc_device i_sbsc_device (.mclk(mclk), .rst_n(rst_n), .link(l.device));
  sbsc_device i_sbsc_device_b (.mclk(mclk), .rst_n(rst_n), .link(l2.device));
  sbsc_controller i_sbsc_controller (.mclk(mclk), .rst_n(rst_n), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .reqLanes(reqLanes),
    .sleepReq(sleepReq), .orderInterleaved(1'b1), .reqReady(reqReady),
    .rdValid(rdValid), .rdData(rdData), .sleeping(sleeping), .link(l.controller));
  sbsc_link_monitor i_sbsc_link_monitor (.mclk(mclk), .rst_n(rst_n),
    .chip_select_primary_n(l.chip_select_primary_n),
    .processor_addr_strobe_n(l.processor_addr_strobe_n),
    .controller_addr_strobe_n(l.controller_addr_strobe_n),
    .global_write_n(l.global_write_n), .byte_write_enable_n(l.byte_write_enable_n),
    .byte_lane_select_n(l.byte_lane_select_n), .outEnableN(l.outEnableN),
    .sleep_request(l.sleep_request), .dqCtlOeN(l.dqCtlOeN), .dqDevOeN(l.dqDevOeN));
  // Compare and count
  task automatic chk(input string n, input sbsc_data_t e, input sbsc_data_t g);
    total_checks++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : chk
  // Verdict; the only place the run ends
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  // One user order, held until the edge that takes it
  task automatic req(input logic w, input sbsc_addr_t a, input sbsc_data_t d,
    input logic [1:0] n);
    @(posedge mclk);
    {reqValid, reqWrite, reqAddr, reqData, reqLanes} <= {1'b1, w, a, d, n};
    @(negedge mclk);
    repeat (20)
      if (reqReady !== 1'b1)
        @(negedge mclk);
    @(posedge mclk);
    reqValid <= 1'b0;
  endtask : req
  // Read, then judge the word that comes with rdValid
  task automatic rd(input sbsc_addr_t a, input sbsc_data_t e);
    req(1'b0, a, '0, 2'h0);
    repeat (8)
      if (rdValid !== 1'b1)
        @(negedge mclk);
    chk("rdValid", 18'h1, 18'(rdValid));
    chk("rdData", e, rdData);
  endtask : rd
  // Whole words back to back, then both read back
  task automatic t_words;
    req(1'b1, 18'h00013, 18'h2a5c3, 2'h3);
    req(1'b1, 18'h3fffc, 18'h15a3c, 2'h3);
    rd(18'h00013, 18'h2a5c3);
    rd(18'h3fffc, 18'h15a3c);
  endtask : t_words
  // One lane at a time; the other lane keeps its byte and parity bit
  task automatic t_lanes;
    req(1'b1, 18'h00013, 18'h3ffff, 2'h1);
    rd(18'h00013, 18'h2a5ff);
    req(1'b1, 18'h00013, 18'h00000, 2'h2);
    rd(18'h00013, 18'h001ff);
  endtask : t_lanes
  // Sleep refuses orders but keeps what is stored
  task automatic t_sleep;
    @(posedge mclk);
    sleepReq <= 1'b1;
    repeat (12)
      @(negedge mclk);
    chk("sleeping", 18'h1, 18'(sleeping));
    chk("reqReady", 18'h0, 18'(reqReady));
    @(posedge mclk);
    sleepReq <= 1'b0;
    rd(18'h3fffc, 18'h15a3c);
  endtask : t_sleep
  // Second link: four writes, then a processor-strobe burst with one
  // held beat; selects stay on, so no first-beat masking
  task automatic t_burst(input logic ord, input logic [1:0] s);
    int i;
    logic [1:0] k;
    for (i = 0; i < 4; i++)
    begin
      @(posedge mclk);
      l2.addr <= {16'h0123, 2'(i)};
      l2.dqFromCtl <= 18'h2c000 + 18'(i);
      {l2.controller_addr_strobe_n, l2.global_write_n, l2.dqCtlOeN} <= 3'b000;
    end
    @(posedge mclk);
    {l2.controller_addr_strobe_n, l2.global_write_n, l2.dqCtlOeN} <= 3'b111;
    l2.burstOrder <= ord;
    @(posedge mclk);
    l2.addr <= {16'h0123, s};
    {l2.processor_addr_strobe_n, l2.outEnableN} <= 2'b00;
    // Data lag the sampled address and advance by one edge
    for (i = 0; i < 6; i++)
    begin
      @(posedge mclk);
      l2.processor_addr_strobe_n <= 1'b1;
      l2.burst_advance_n <= (i == 1 || i > 3);
      @(negedge mclk);
      k = 2'(i - 1 - (i > 2));
      k = ord ? s ^ k : s + k;
      if (i > 0)
        chk("burst", 18'h2c000 + 18'(k), l2.dqBus);
    end
    @(posedge mclk);
    {l2.burst_advance_n, l2.outEnableN} <= 2'b11;
  endtask : t_burst
  // Second link: both strobes low start a read that ignores the write
  // controls; lane 1 is written a cycle later, lane 0 keeps its byte
  task automatic t_pwrite;
    @(posedge mclk);
    {l2.addr, l2.dqFromCtl} <= {18'h00abc, 18'h00155};
    {l2.controller_addr_strobe_n, l2.global_write_n, l2.dqCtlOeN} <= 3'b000;
    @(posedge mclk);
    l2.processor_addr_strobe_n <= 1'b0;
    l2.dqFromCtl <= 18'h3ffff;
    @(posedge mclk);
    {l2.processor_addr_strobe_n, l2.controller_addr_strobe_n} <= 2'b11;
    {l2.global_write_n, l2.byte_write_enable_n, l2.byte_lane_select_n} <= 4'b1001;
    l2.dqFromCtl <= 18'h2a800;
    @(posedge mclk);
    {l2.byte_write_enable_n, l2.byte_lane_select_n, l2.dqCtlOeN} <= 4'hf;
    @(posedge mclk);
    {l2.processor_addr_strobe_n, l2.outEnableN} <= 2'b00;
    @(posedge mclk);
    l2.processor_addr_strobe_n <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    chk("pwrite", 18'h2a955, l2.dqBus);
    @(posedge mclk);
    l2.outEnableN <= 1'b1;
  endtask : t_pwrite
  // Reset for ten cycles, then the scenarios
  initial
  begin
    {reqValid, reqWrite, sleepReq, reqLanes, reqAddr, reqData} = '0;
    {l2.chip_select_primary_n, l2.chip_select_expand_hi, l2.chip_select_expand_n} = 3'b010;
    {l2.processor_addr_strobe_n, l2.controller_addr_strobe_n, l2.burst_advance_n} = 3'b111;
    {l2.global_write_n, l2.byte_write_enable_n, l2.byte_lane_select_n} = 4'hf;
    {l2.outEnableN, l2.sleep_request, l2.burstOrder, l2.dqCtlOeN} = 4'hb;
    {l2.addr, l2.dqFromCtl} = '0;
    rst_n = 1'b0;
    repeat (10)
      @(posedge mclk);
    rst_n <= 1'b1;
    t_words;
    t_lanes;
    t_sleep;
    t_burst(1'b1, 2'h2);
    t_burst(1'b0, 2'h1);
    t_pwrite;
    conclude;
  end
  // Hang guard, over twenty times the expected run
  initial
  begin
    repeat (3000)
      @(posedge mclk);
    fail_count++;
    conclude;
  end
endmodule : sync_burst_sram_control_tb
